// ===== dv/memory_space_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module memory_space_decoder_tb;
    import memdec_pkg::*;
    logic clock_i, sys_rst_i, fetch_i, prog_rd_o, data_rd_i, data_wr_i;
    logic sel_ram_o, sel_core_o, sel_periph_o, sel_int_opt_o, sel_acc_o;
    logic win_hit_o, push_i, pop_i, ext_rd_i, ext_rd_o, ext_refused_o;
    logic protect_bit_i, full_erase_i, vpp_high_i, prog_mode_o;
    logic [11:0] program_counter_i, prog_addr_o, push_addr_i, pop_addr_o;
    logic [11:0] ext_addr_i;
    logic [7:0] prog_data_i, data_addr_i, data_wdata_i, win_data_o;
    logic [2:0] stack_level_o;
    int miscompares = 0; // mismatch count
    int n_compared = 0;  // comparison count
    memory_space_decoder dut (.clock_i, .sys_rst_i, .program_counter_i,
        .fetch_i, .prog_addr_o, .prog_rd_o, .prog_data_i, .data_addr_i,
        .data_rd_i, .data_wr_i, .data_wdata_i, .sel_ram_o, .sel_core_o,
        .sel_periph_o, .sel_int_opt_o, .sel_acc_o, .win_hit_o, .win_data_o,
        .push_i, .pop_i, .push_addr_i, .pop_addr_o, .stack_level_o, .ext_rd_i,
        .ext_addr_i, .ext_rd_o, .ext_refused_o, .protect_bit_i, .full_erase_i,
        .vpp_high_i, .prog_mode_o);
    prog_mem_model u_mem (.clock_i, .addr_i(prog_addr_o), .rd_i(prog_rd_o),
        .prog_data_o(prog_data_i));
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    // inputs move 1 ns after the edge
    task automatic step;
        @(posedge clock_i);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [11:0] e, g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // vpp level is captured in the final reset cycle
    task automatic rst(input logic v);
        sys_rst_i = 1'b1;
        vpp_high_i = v;
        repeat (5) step;
        sys_rst_i = 1'b0;
        vpp_high_i = 1'b0;
        step;
    endtask : rst
    task automatic t_decode;
        logic [12:0] t [11] = '{{8'h00, 5'h10}, {8'h3F, 5'h10},
            {8'h40, 5'h00}, {8'h80, 5'h08}, {8'h83, 5'h08}, {8'h84, 5'h00},
            {8'hC0, 5'h04}, {8'hC8, 5'h02}, {8'hC9, 5'h00}, {8'hFE, 5'h04},
            {8'hFF, 5'h01}};
        fetch_i = 1'b1;
        foreach (t[i]) begin
            data_addr_i = t[i][12:5];
            program_counter_i = ~{4'h0, t[i][12:5]};
            step;
            chk("sel", t[i][4:0], {sel_ram_o, sel_core_o, sel_periph_o,
                sel_int_opt_o, sel_acc_o});
            chk("pc", ~{4'h0, t[i][12:5]}, prog_addr_o);
            chk("fetch", 1'b1, prog_rd_o);
        end
        fetch_i = 1'b0;
        $display("decode test done");
    endtask : t_decode
    task automatic t_window;
        logic [11:0] a [2] = '{12'hA85, 12'hFFF};
        foreach (a[i]) begin
            data_rd_i = 1'b0;
            data_wr_i = 1'b1;
            data_addr_i = 8'hC9;
            data_wdata_i = {2'h0, a[i][11:6]};
            step;
            data_wr_i = 1'b0;
            data_rd_i = 1'b1;
            data_addr_i = {2'h1, a[i][5:0]};
            step;
            chk("hit", 1'b1, win_hit_o);
            chk("win", a[i][7:0] ^ {a[i][11:8], 4'hA}, win_data_o);
        end
        data_rd_i = 1'b0;
        $display("window test done");
    endtask : t_window
    task automatic t_stack;
        for (int i = 1; i <= 7; i++) begin
            push_i = 1'b1;
            push_addr_i = 12'(i * 585);
            step;
            push_i = 1'b0;
            step;
        end
        chk("level", 3'h6, stack_level_o);
        for (int i = 7; i >= 2; i--) begin
            step;
            chk("top", 12'(i * 585), pop_addr_o);
            pop_i = 1'b1;
            step;
            pop_i = 1'b0;
            step;
        end
        chk("empty", 3'h0, stack_level_o);
        pop_i = 1'b1;
        step;
        pop_i = 1'b0;
        step;
        chk("underflow", 3'h0, stack_level_o);
        $display("stack test done");
    endtask : t_stack
    // a refused read must not reach the program port at all
    task automatic ext(input logic ok);
        ext_addr_i = 12'hABC;
        ext_rd_i = 1'b1;
        #2;
        chk("eaddr", ok ? ext_addr_i : program_counter_i,
            prog_addr_o);
        chk("erd", ok, prog_rd_o);
        step;
        ext_rd_i = 1'b0;
        chk("grant", ok, ext_rd_o);
        chk("refuse", !ok, ext_refused_o);
    endtask : ext
    // protection and erase pass a two-flop synchroniser
    task automatic t_ext;
        chk("mode", 1'b0, prog_mode_o);
        ext(1'b0);
        rst(1'b1);
        step;
        chk("mode", 1'b1, prog_mode_o);
        ext(1'b1);
        protect_bit_i = 1'b1;
        repeat (4) step;
        ext(1'b0);
        protect_bit_i = 1'b0;
        repeat (4) step;
        ext(1'b0);
        full_erase_i = 1'b1;
        repeat (4) step;
        full_erase_i = 1'b0;
        step;
        ext(1'b1);
        rst(1'b0);
        chk("mode", 1'b0, prog_mode_o);
        $display("programmer test done");
    endtask : t_ext
    task automatic close_out;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    initial begin
        {sys_rst_i, fetch_i, data_rd_i, data_wr_i, push_i, pop_i, ext_rd_i,
            protect_bit_i, full_erase_i, vpp_high_i, program_counter_i,
            data_addr_i, data_wdata_i, push_addr_i, ext_addr_i} = '0;
        rst(1'b0);
        t_decode;
        t_window;
        t_stack;
        t_ext;
        close_out;
    end
    // the whole run needs under a hundred cycles
    initial begin
        repeat (5000) @(posedge clock_i);
        miscompares++;
        close_out;
    end
endmodule : memory_space_decoder_tb
`default_nettype wire

// ===== dv/msd_sva.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the decoder, one clock domain
module msd_sva
    import memdec_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire logic [7:0]  data_addr_i,
    input wire logic        data_rd_i,
    input wire logic [7:0]  prog_data_i,
    input wire logic        sel_ram_o,
    input wire logic        sel_periph_o,
    input wire logic        sel_int_opt_o,
    input wire logic        sel_acc_o,
    input wire logic        win_hit_o,
    input wire logic [7:0]  win_data_o,
    input wire logic        push_i,
    input wire logic        pop_i,
    input wire logic [2:0]  stack_level_o,
    input wire logic        ext_rd_i,
    input wire logic        ext_rd_o,
    input wire logic        ext_refused_o,
    input wire logic        prog_mode_o,
    input wire logic        prog_rd_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // ram never overlaps the window
    property p_ram; data_addr_i <= RAM_HI |-> sel_ram_o && !win_hit_o;
    endproperty
    a_ram: assert property (p_ram) else $error("ram select wrong");
    property p_win;
        data_rd_i && data_addr_i inside {[WIN_LO:WIN_HI]}
            |-> win_hit_o && !sel_ram_o;
    endproperty
    a_win: assert property (p_win) else $error("window hit wrong");
    // latched byte is the one present at the hit edge
    property p_wdat; win_hit_o |=> win_data_o == $past(prog_data_i);
    endproperty
    a_wdat: assert property (p_wdat) else $error("window data");
    // a window read always claims the program port
    property p_wport; win_hit_o |-> prog_rd_o; endproperty
    a_wport: assert property (p_wport) else $error("window port");
    property p_iopt;
        data_addr_i == INT_OPT_ADR |-> sel_int_opt_o && !sel_periph_o;
    endproperty
    a_iopt: assert property (p_iopt) else $error("option select");
    property p_acc; data_addr_i == ACC_ADR |-> sel_acc_o && !sel_periph_o;
    endproperty
    a_acc: assert property (p_acc) else $error("acc select");
    property p_push;
        push_i && stack_level_o < 3'h6
            |=> stack_level_o == $past(stack_level_o) + 3'h1;
    endproperty
    a_push: assert property (p_push) else $error("push level");
    // full stack keeps its depth, oldest dropped
    property p_full; push_i && stack_level_o == 3'h6 |=> stack_level_o == 3'h6;
    endproperty
    a_full: assert property (p_full) else $error("overflow level");
    property p_pop;
        pop_i && !push_i && stack_level_o != 3'h0
            |=> stack_level_o == $past(stack_level_o) - 3'h1;
    endproperty
    a_pop: assert property (p_pop) else $error("pop level");
    // every request gets exactly one answer
    property p_ext; ext_rd_i |=> ext_rd_o != ext_refused_o; endproperty
    a_ext: assert property (p_ext) else $error("ext answer");
    property p_grant; ext_rd_o |-> prog_mode_o; endproperty
    a_grant: assert property (p_grant)
        else $error("grant outside mode");
    c_win: cover property (win_hit_o);
    c_full: cover property (push_i && stack_level_o == 3'h6);
    c_ref: cover property (ext_refused_o);
    c_grant: cover property (ext_rd_o);
endmodule : msd_sva
bind memory_space_decoder msd_sva u_sva (.clock_i, .sys_rst_i, .data_addr_i,
    .data_rd_i, .prog_data_i, .sel_ram_o, .sel_periph_o, .sel_int_opt_o,
    .sel_acc_o, .win_hit_o, .win_data_o, .push_i, .pop_i, .stack_level_o,
    .ext_rd_i, .ext_rd_o, .ext_refused_o, .prog_mode_o, .prog_rd_o);
`default_nettype wire

// ===== dv/prog_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// program memory beside the core, serves fetch, window, programmer bytes
module prog_mem_model (
    input wire logic        clock_i,
    input wire logic [11:0] addr_i,
    input wire logic        rd_i,
    output logic     [7:0]  prog_data_o
);
    logic [7:0] held; // last byte driven
    // idle bus toggles so a stale byte never looks valid
    always_comb begin
        if (rd_i)
            prog_data_o = addr_i[7:0] ^ {addr_i[11:8], 4'hA};
        else
            prog_data_o = ~held;
    end
    always_ff @(posedge clock_i) begin
        held <= prog_data_o;
    end
endmodule : prog_mem_model
`default_nettype wire

// ===== inc/memdec_pkg.sv
package memdec_pkg;
    // address widths and return stack
    localparam int PROG_AW        = 12;      // program counter width
    localparam int DATA_AW        = 8;       // data space address width
    localparam int STACK_DEPTH    = 6;       // return stack levels
    localparam int STACK_PW       = 3;       // stack pointer width
    // data space map
    localparam logic [7:0] RAM_LO      = 8'h00;
    localparam logic [7:0] RAM_HI      = 8'h3F;
    localparam logic [7:0] WIN_LO      = 8'h40;
    localparam logic [7:0] WIN_HI      = 8'h7F;
    localparam logic [7:0] CORE_LO     = 8'h80;
    localparam logic [7:0] CORE_HI     = 8'h83;
    localparam logic [7:0] PERIPH_LO   = 8'hC0;
    localparam logic [7:0] PERIPH_HI   = 8'hFE;
    localparam logic [7:0] INT_OPT_ADR = 8'hC8;
    localparam logic [7:0] WIN_SEL_ADR = 8'hC9;
    localparam logic [7:0] ACC_ADR     = 8'hFF;
    localparam int WIN_SEL_W      = 6;       // block select bits
    localparam int WIN_OFS_W      = 6;       // offset inside a block
    // reset values
    localparam logic [2:0] SP_RESET    = 3'h0;
    // programming-mode capture state
    typedef enum logic [1:0] {
        PM_RESET = 2'b00,
        PM_PROG  = 2'b01,
        PM_RUN   = 2'b10
    } pm_state_e;
endpackage : memdec_pkg

// ===== inc/stack_if.sv
`timescale 1ns/1ps
`default_nettype none
// return stack control and data between decoder and storage
interface stack_if;
    logic                              push;     // store one entry
    logic                              pop;      // take one entry
    logic [memdec_pkg::STACK_PW-1:0]   wr_ptr;   // slot to write
    logic [memdec_pkg::STACK_PW-1:0]   rd_ptr;   // slot to read
    logic [memdec_pkg::PROG_AW-1:0]    wr_data;  // pushed address
    logic [memdec_pkg::PROG_AW-1:0]    rd_data;  // registered read
    modport ctrl (output push, pop, wr_ptr, rd_ptr, wr_data,
                  input rd_data);
    modport mem  (input push, pop, wr_ptr, rd_ptr, wr_data,
                  output rd_data);
endinterface : stack_if
`default_nettype wire

// ===== rtl/memory_space_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module memory_space_decoder
    import memdec_pkg::*;
(
    input  wire logic               clock_i,
    input  wire logic               sys_rst_i,
    // program fetch side
    input  wire logic [PROG_AW-1:0] program_counter_i,
    input  wire logic               fetch_i,
    output logic      [PROG_AW-1:0] prog_addr_o,
    output logic                    prog_rd_o,
    input  wire logic [7:0]         prog_data_i,
    // data space side
    input  wire logic [DATA_AW-1:0] data_addr_i,
    input  wire logic               data_rd_i,
    input  wire logic               data_wr_i,
    input  wire logic [7:0]         data_wdata_i,
    output logic                    sel_ram_o,
    output logic                    sel_core_o,
    output logic                    sel_periph_o,
    output logic                    sel_int_opt_o,
    output logic                    sel_acc_o,
    output logic                    win_hit_o,
    output logic      [7:0]         win_data_o,
    // stack side
    input  wire logic               push_i,
    input  wire logic               pop_i,
    input  wire logic [PROG_AW-1:0] push_addr_i,
    output logic      [PROG_AW-1:0] pop_addr_o,
    output logic      [STACK_PW-1:0] stack_level_o,
    // external programmer access
    input  wire logic               ext_rd_i,
    input  wire logic [PROG_AW-1:0] ext_addr_i,
    output logic                    ext_rd_o,
    output logic                    ext_refused_o,
    // option and erase
    input  wire logic               protect_bit_i,
    input  wire logic               full_erase_i,
    // programming voltage pin, high-level comparator output
    input  wire logic               vpp_high_i,
    output logic                    prog_mode_o
);
    // ---------------- pin synchronisers ----------------
    logic vpp_s1;          // first stage, read only by vpp_s2
    logic vpp_s2;          // usable level
    logic prot_s1;
    logic prot_s2;
    logic erase_s1;        // erase request, first stage
    logic erase_s2;        // erase request, usable level
    always_ff @(posedge clock_i) begin
        vpp_s1   <= vpp_high_i;
        vpp_s2   <= vpp_s1;
        prot_s1  <= protect_bit_i;
        prot_s2  <= prot_s1;
        erase_s1 <= full_erase_i;
        erase_s2 <= erase_s1;
    end

    // program port is driven near the end, once all its sources exist

    // ---------------- window select ----------------
    // no reset: value is undefined until software writes it
    logic [WIN_SEL_W-1:0] rom_window_select;
    logic [WIN_SEL_W-1:0] next_rom_window_select;
    always_comb begin
        next_rom_window_select = rom_window_select;
        // bits 7:6 ignored; register has no read path
        if (data_wr_i && data_addr_i == WIN_SEL_ADR) begin
            next_rom_window_select = data_wdata_i[WIN_SEL_W-1:0];
        end
    end
    always_ff @(posedge clock_i) begin
        rom_window_select <= next_rom_window_select;
    end

    // ---------------- data space decode ----------------
    logic in_win;
    always_comb begin
        in_win        = data_addr_i >= WIN_LO && data_addr_i <= WIN_HI;
        sel_ram_o     = data_addr_i <= RAM_HI;
        sel_core_o    = data_addr_i >= CORE_LO && data_addr_i <= CORE_HI;
        sel_periph_o  = data_addr_i >= PERIPH_LO && data_addr_i <= PERIPH_HI
                        && data_addr_i != WIN_SEL_ADR
                        && data_addr_i != INT_OPT_ADR;
        sel_int_opt_o = data_addr_i == INT_OPT_ADR;
        sel_acc_o     = data_addr_i == ACC_ADR;
        win_hit_o     = in_win && data_rd_i;
    end

    // window reads share program memory through the one program port
    logic [PROG_AW-1:0] win_addr;
    always_comb begin
        win_addr = {rom_window_select, data_addr_i[WIN_OFS_W-1:0]};
    end

    // ---------------- programming mode capture ----------------
    pm_state_e pm_state;
    pm_state_e next_pm_state;
    always_comb begin
        next_pm_state = pm_state;
        case (pm_state)
            // decided from the pin level latched while reset was held
            PM_RESET: next_pm_state = pm_latched ? PM_PROG : PM_RUN;
            PM_PROG:  next_pm_state = PM_PROG;
            PM_RUN:   next_pm_state = PM_RUN;
            default:  next_pm_state = PM_RESET;
        endcase
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pm_state <= PM_RESET;
        end else begin
            pm_state <= next_pm_state;
        end
    end
    // capture during reset phase: level seen while reset held
    logic pm_latched;
    logic next_pm_latched;
    always_comb begin
        next_pm_latched = pm_latched;
        if (sys_rst_i) begin
            next_pm_latched = vpp_s2;
        end
    end
    always_ff @(posedge clock_i) begin
        pm_latched <= next_pm_latched;
    end

    // ---------------- readout protection ----------------
    // sticky once set; only a full erase or a reset drops it
    logic prot;
    logic next_prot;
    always_comb begin
        next_prot = prot;
        if (erase_s2) begin
            next_prot = 1'b0;
        end
        if (prot_s2) begin
            next_prot = 1'b1;          // set wins over clear
        end
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            prot <= 1'b0;
        end else begin
            prot <= next_prot;
        end
    end

    // ---------------- registered data outputs ----------------
    logic       ext_ok;
    logic       next_ext_ok;
    logic       next_refused;
    logic [7:0] next_win_data;
    logic       prog_mode;
    always_comb begin
        prog_mode     = pm_state == PM_PROG;
        next_ext_ok   = ext_rd_i && prog_mode && !(prot || prot_s2);
        next_refused  = ext_rd_i && !next_ext_ok;
        next_win_data = win_data_o;
        if (win_hit_o) begin
            next_win_data = prog_data_i;
        end
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ext_ok        <= 1'b0;
            ext_refused_o <= 1'b0;
            win_data_o    <= 8'h00;
            prog_mode_o   <= 1'b0;
        end else begin
            ext_ok        <= next_ext_ok;
            ext_refused_o <= next_refused;
            win_data_o    <= next_win_data;
            prog_mode_o   <= prog_mode;
        end
    end
    assign ext_rd_o = ext_ok;

    // ---------------- return stack ----------------
    stack_if st ();
    logic [STACK_PW-1:0] level;      // entries held
    logic [STACK_PW-1:0] base;       // oldest slot
    logic [STACK_PW-1:0] next_level;
    logic [STACK_PW-1:0] next_base;
    logic [STACK_PW-1:0] top;        // newest slot
    logic [STACK_PW-1:0] wr_slot;
    function automatic logic [STACK_PW-1:0] wrap(input logic [3:0] v);
        wrap = (v >= 4'(STACK_DEPTH)) ? 3'(v - 4'(STACK_DEPTH)) : v[2:0];
    endfunction : wrap
    always_comb begin
        next_level = level;
        next_base  = base;
        top        = wrap({1'b0, base} + {1'b0, level} + 4'hF + 4'h0);
        wr_slot    = wrap({1'b0, base} + {1'b0, level});
        if (level == 3'(STACK_DEPTH)) begin
            wr_slot = base;          // overwrite the oldest
        end
        if (push_i) begin
            if (level == 3'(STACK_DEPTH)) begin
                next_base = wrap({1'b0, base} + 4'h1);
            end else begin
                next_level = level + 3'h1;
            end
        end else if (pop_i && level != SP_RESET) begin
            next_level = level - 3'h1;
        end
    end
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            level <= SP_RESET;
            base  <= SP_RESET;
        end else begin
            level <= next_level;
            base  <= next_base;
        end
    end
    // stack slots are private storage, never on the data bus
    assign st.push    = push_i;
    assign st.pop     = pop_i;
    assign st.wr_ptr  = wr_slot;
    assign st.rd_ptr  = (level == SP_RESET) ? base : top;
    assign st.wr_data = push_addr_i;
    assign pop_addr_o    = st.rd_data;
    assign stack_level_o = level;

    return_stack_mem u_stack (
        .clock_i (clock_i),
        .st      (st)
    );

    // ---------------- shared program port ----------------
    // fetch, window reads and permitted programmer reads share one port;
    // a window read steals the cycle from a fetch, so the core must not
    // fetch while reading the window; a refused read never reaches memory
    always_comb begin
        prog_addr_o = program_counter_i;
        prog_rd_o   = fetch_i;
        if (win_hit_o) begin
            prog_addr_o = win_addr;
            prog_rd_o   = 1'b1;
        end else if (next_ext_ok) begin
            prog_addr_o = ext_addr_i;
            prog_rd_o   = 1'b1;
        end
    end
endmodule : memory_space_decoder
`default_nettype wire

// ===== rtl/return_stack_mem.sv
`timescale 1ns/1ps
`default_nettype none
module return_stack_mem
    import memdec_pkg::*;
(
    input  wire logic clock_i,
    stack_if.mem      st
);
    // storage, not reset: contents are only meaningful after a push
    logic [PROG_AW-1:0] slot [STACK_DEPTH];
    logic [PROG_AW-1:0] rd_q;

    // each slot loads when addressed by a push
    for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_slot
        always_ff @(posedge clock_i) begin
            if (st.push && st.wr_ptr == STACK_PW'(g)) begin
                slot[g] <= st.wr_data;
            end
        end
    end

    // registered read port
    always_ff @(posedge clock_i) begin
        rd_q <= slot[st.rd_ptr];
    end
    assign st.rd_data = rd_q;
endmodule : return_stack_mem
`default_nettype wire
